// ==== homing_and_sync_input_control_test.sv ====
// Self-checking bench for the homing sequencer and the sync input conditioner.
`timescale 1ns/1ps
module homing_and_sync_input_control_test;
   import hsic_pkg::*;
   logic aclk = 0, aresetn = 0, ce = 1, sync_lvl = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
   logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
   logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0000_0000, stop_dly = 32'h0000_0014, step_count, s_axi_rdata;
   logic [3:0]  s_axi_wstrb = 4'hf;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic        move_done, homing_busy, homing_done;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   hsic_pins_t  pins_in;
   hsic_move_t  move_out;
   hsic_move_t  mq[$];
   int          tq[$];
   int          cyc = 0, num_errors = 0, checks = 0;
   hsic_top dut (.*);
   hsic_far_model far (.aclk(aclk), .move_out(move_out), .sync_lvl(sync_lvl),
      .stop_dly(stop_dly), .pins_in(pins_in), .step_count(step_count), .move_done(move_done));
   always #2.5 aclk = ~aclk;
   ////////////////////////////////////////////////////////////////////////////////
   // Log every move pulse with its cycle number, since phase lengths reveal the stop source.
   always @(posedge aclk)
   begin
      cyc <= cyc + 1;
      if (move_out.valid === 1'b1) mq.push_back(move_out);
      if (move_out.valid === 1'b1) tq.push_back(cyc);
   end
   task chk(input logic [31:0] got, exp, input string msg);
      checks++;
      if (got !== exp)
      begin
         num_errors++;
         $display("CHECK FAILED at %0t: %s got %h exp %h", $time, msg, got, exp);
      end
   endtask : chk
   // Checks search flag and direction of one logged move, then its speed or target.
   task chkm(input int i, input logic [1:0] k, input logic [31:0] v, input bit tgt);
      hsic_move_t m;
      m = (i < mq.size()) ? mq[i] : '0;
      chk({30'h0, m.search, m.dir_left}, {30'h0, k}, "move kind");
      chk(tgt ? m.target : m.speed, v, "move value");
   endtask : chkm
   ////////////////////////////////////////////////////////////////////////////////
   // Bus tasks sample the readies a little after an edge, once the design has settled.
   task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'b00);
      logic aw, w;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      repeat (50)
      begin
         #1;
         if (s_axi_bvalid === 1'b1) break;
         aw = s_axi_awvalid & s_axi_awready;
         w = s_axi_wvalid & s_axi_wready;
         @(posedge aclk);
         if (aw) s_axi_awvalid <= 1'b0;
         if (w) s_axi_wvalid <= 1'b0;
      end
      chk({31'h0, s_axi_bvalid}, 32'h1, "write answer");
      @(posedge aclk);
      chk({30'h0, s_axi_bresp}, {30'h0, er}, "write response");
      s_axi_bready <= 1'b0;
      @(posedge aclk);
   endtask : wr
   task rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er = 2'b00);
      logic ar;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      repeat (50)
      begin
         #1;
         if (s_axi_rvalid === 1'b1) break;
         ar = s_axi_arvalid & s_axi_arready;
         @(posedge aclk);
         if (ar) s_axi_arvalid <= 1'b0;
      end
      chk({31'h0, s_axi_rvalid}, 32'h1, "read answer");
      @(posedge aclk);
      chk(s_axi_rdata, exp, "read data");
      chk({30'h0, s_axi_rresp}, {30'h0, er}, "read response");
      s_axi_rready <= 1'b0;
      @(posedge aclk);
   endtask : rd
   // Starts homing and waits for completion with the given number of moves logged.
   task home(input logic [31:0] ctrl, input int n);
      mq.delete();
      tq.delete();
      wr(8'h00, ctrl);
      chk({31'h0, homing_busy}, 32'h1, "busy flag");
      repeat (3000)
      begin
         @(posedge aclk);
         if (homing_done === 1'b1 && mq.size() >= n) break;
      end
      chk(mq.size(), n, "move count");
      chk({30'h0, homing_done, homing_busy}, 32'h2, "done and idle");
   endtask : home
   ////////////////////////////////////////////////////////////////////////////////
   task t_regs;
      rd(8'h10, 32'h0004_0000);
      rd(8'h20, 32'h0000_0064);
      rd(8'h30, 32'h0000_0000, 2'b10);
      wr(8'h30, 32'h0000_0001, 2'b10);
      wr(8'h04, 32'h0000_0064);
      rd(8'h04, 32'h0000_0064);
      $display("register test done");
   endtask : t_regs
   // Standard run: sensor stops phase one early, the left end switch stops phase two later.
   task t_std;
      wr(8'h08, 32'h0000_000a);
      wr(8'h0c, 32'hffff_ff9c);
      home(32'h0000_010d, 3);
      chkm(0, 2'b10, 32'h0000_0064, 0);
      chkm(1, 2'b11, 32'h0000_000a, 0);
      chkm(2, 2'b01, 32'hffff_ff9c, 1);
      chk({31'h0, tq[1] - tq[0] < 30}, 32'h1, "phase one length");
      chk({31'h0, tq[2] - tq[1] >= 40}, 32'h1, "phase two length");
      chk({31'h0, homing_done}, 32'h1, "done flag");
      $display("standard homing test done");
   endtask : t_std
   task t_fast;
      wr(8'h0c, 32'h0000_0032);
      home(32'h0000_0523, 3);
      chkm(0, 2'b11, 32'h0000_000a, 0);
      chkm(1, 2'b11, 32'h0000_0064, 0);
      chkm(2, 2'b00, 32'h0000_0032, 1);
      home(32'h0000_0101, 2);
      chkm(0, 2'b10, 32'h0000_0064, 0);
      chkm(1, 2'b00, 32'h0000_0032, 1);
      $display("fast and single phase test done");
   endtask : t_fast
   task t_blind;
      stop_dly <= 32'h0000_000a;
      wr(8'h20, 32'h0000_003c);
      home(32'h0000_0519, 3);
      chk({31'h0, tq[2] - tq[1] >= 60}, 32'h1, "blind span");
      $display("blind half turn test done");
   endtask : t_blind
   // Short pulse, gap, long pulse; the move lands before the fall unless inverted.
   task sync(input logic [31:0] cfg, dest, input int n, input logic [31:0] tg);
      int fall;
      wr(8'h10, cfg);
      wr(8'h24, dest);
      mq.delete();
      tq.delete();
      sync_lvl <= 1'b1;
      repeat (100) @(posedge aclk);
      sync_lvl <= 1'b0;
      repeat (400) @(posedge aclk);
      sync_lvl <= 1'b1;
      repeat (400) @(posedge aclk);
      fall = cyc;
      sync_lvl <= 1'b0;
      repeat (400) @(posedge aclk);
      chk(mq.size(), n, "sync move count");
      if (n > 0) chk(mq[0].target, tg, "sync target");
      if (n > 0) chk(mq[0].speed, 32'h0000_004d, "sync speed");
      if (n > 0) chk({31'h0, mq[0].relative}, {31'h0, !cfg[2]}, "sync relative");
      if (n > 0) chk({31'h0, tq[0] > fall}, {31'h0, cfg[1]}, "sync edge");
   endtask : sync
   task t_sync;
      wr(8'h14, 32'h0000_1234);
      wr(8'h18, 32'h0000_004d);
      sync(32'h0001_0004, 32'h0000_0000, 0, 32'h0000_0000);
      sync(32'h0001_0005, 32'h0000_0000, 1, 32'h0000_1234);
      sync(32'h0001_0007, 32'h0000_0000, 1, 32'h0000_1234);
      sync(32'h0001_0001, 32'h0000_0064, 1, 32'h0000_1298);
      $display("sync input test done");
   endtask : t_sync
   task print_verdict;
      $display("checks %0d mismatches %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : print_verdict
   ////////////////////////////////////////////////////////////////////////////////
   // The whole run needs some 6k cycles; the watchdog allows about seven times that.
   initial
   begin
      #200_000;
      num_errors++;
      print_verdict();
   end
   initial
   begin
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      t_regs();
      t_std();
      t_fast();
      t_blind();
      t_sync();
      print_verdict();
   end
endmodule : homing_and_sync_input_control_test

// ==== hsic_far_model.sv ====
// Far-side model: end switches, revolution sensor, sync line and a plain motion generator.
`timescale 1ns/1ps
module hsic_far_model
   import hsic_pkg::*;
(
   input  wire logic        aclk,
   input  wire hsic_move_t  move_out,
   input  wire logic        sync_lvl,
   input  wire logic [31:0] stop_dly,
   output hsic_pins_t       pins_in,
   output logic [31:0]      step_count,
   output logic             move_done
);
   hsic_move_t  cmd_ff = '0;
   logic [31:0] age_ff = '0;
   initial step_count = 32'h0000_0000;
   ////////////////////////////////////////////////////////////////////////////////
   // Age counts cycles since the last command; the stage steps once a cycle while busy.
   always @(posedge aclk)
   begin
      age_ff <= move_out.valid ? 32'h0000_0000 : age_ff + 32'h0000_0001;
      if (move_out.valid) cmd_ff <= move_out;
      if (!move_done) step_count <= cmd_ff.dir_left ? step_count - 1 : step_count + 1;
   end
   // A plain move settles after four cycles; a search runs until a new command.
   assign move_done = !cmd_ff.search && age_ff >= 32'h0000_0004;
   // The sensor fires at the delay and the end switch at twice it, so sources differ in time.
   assign pins_in.rev       = cmd_ff.search && age_ff >= stop_dly;
   assign pins_in.lim_left  = cmd_ff.search && cmd_ff.dir_left && age_ff >= (stop_dly << 1);
   assign pins_in.lim_right = cmd_ff.search && !cmd_ff.dir_left && age_ff >= (stop_dly << 1);
   assign pins_in.sync_in   = sync_lvl;
endmodule : hsic_far_model

// ==== hsic_pkg.sv ====
// Types shared by the homing and sync block.
package hsic_pkg;
   typedef enum logic [1:0] {HSIC_SRC_LIMIT, HSIC_SRC_REV, HSIC_SRC_SYNC} hsic_src_t;
   typedef enum logic [2:0] {HSIC_IDLE, HSIC_PH1, HSIC_PH2, HSIC_STANDOFF, HSIC_WAIT_SYNC}
      hsic_phase_t;
   // Move request to the motion generator.
   typedef struct packed {
      logic        valid;
      logic        relative;
      logic        dir_left;
      logic        search;
      logic [31:0] speed;
      logic [31:0] target;
   } hsic_move_t;
   // Switch and sensor pins, raw at the port and after synchronisation.
   typedef struct packed {
      logic lim_left;
      logic lim_right;
      logic rev;
      logic sync_in;
   } hsic_pins_t;
endpackage : hsic_pkg

// ==== hsic_regs.svh ====
// Register offsets, field positions, reset values and timing counts of the homing and sync block.
`ifndef HSIC_REGS_SVH
`define HSIC_REGS_SVH
`define HSIC_CTRL_OFS     8'h00
`define HSIC_HSPD1_OFS    8'h04
`define HSIC_HSPD2_OFS    8'h08
`define HSIC_STANDOFF_OFS 8'h0C
`define HSIC_SCFG_OFS     8'h10
`define HSIC_SPOS_OFS     8'h14
`define HSIC_SSPD_OFS     8'h18
`define HSIC_STAT_OFS     8'h1C
`define HSIC_HALF_OFS     8'h20
`define HSIC_DEST_OFS     8'h24
// CTRL fields.
`define HSIC_C_START      0
`define HSIC_C_DIR1       1
`define HSIC_C_DIR2       2
`define HSIC_C_SEC        3
`define HSIC_C_BLIND      4
`define HSIC_C_FAST       5
`define HSIC_C_SRC1_LO    8
`define HSIC_C_SRC2_LO    10
// SCFG fields.
`define HSIC_S_EN         0
`define HSIC_S_INV        1
`define HSIC_S_ABS        2
`define HSIC_S_CLUT_LO    16
// Reset values.
`define HSIC_CTRL_RST     32'h0000_0000
`define HSIC_SCFG_RST     32'h0004_0000
`define HSIC_HALF_RST     32'h0000_0064
// Timing: one microsecond at a 5 ns clock period.
`define HSIC_CLK_PERIOD_NS 5
`define HSIC_US_NS         1000
`define HSIC_CYC_PER_US    ((`HSIC_US_NS + `HSIC_CLK_PERIOD_NS - 1) / `HSIC_CLK_PERIOD_NS)
`endif

// ==== hsic_top.sv ====
// Homing sequencer and sync input conditioner with an AXI4-Lite register slave.
`timescale 1ns/1ps
`include "hsic_regs.svh"
// Functional notes
// - First-phase search moves in the first-phase direction for standard and fast homing.
// - Standard first phase uses the first-phase speed.
// - Fast homing second phase uses the first-phase speed.
// - A search phase ends on the stop signal of its selected source.
// - The second phase runs only when its enable is set or fast homing is selected.
// - Standard second phase moves in the second-phase direction.
// - Standard second phase uses the second-phase speed.
// - The second phase has its own stop-source selection.
// - Blind half-turn ignores second-phase stop for half a revolution.
// - A final standoff move covers the standoff distance.
// - Standoff sign gives direction: positive right, negative left.
// - Fast setting replaces the standard procedure with the fast one.
// - Sync pulses shorter than the clutter time are rejected.
// - Sync pulses act only while sync input is enabled.
// - With invert set, sync triggers on the falling edge.
// - Absolute sync moves to the configured absolute position.
// - Relative sync shifts the destination by the configured amount.
// - Sync-triggered moves use the sync speed.
module hsic_top
   import hsic_pkg::*;
#(
   parameter int CLUT_W = 16
)(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        ce,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire hsic_pins_t  pins_in,
   input  wire logic [31:0] step_count,
   input  wire logic        move_done,
   output hsic_move_t       move_out,
   output logic             homing_busy,
   output logic             homing_done
);

   ////////////////////////////////////////////////////////////////////////////
   // State of the whole block, one packed struct.
   typedef struct packed {
      logic [31:0] ctrl;
      logic [31:0] spd1;
      logic [31:0] spd2;
      logic [31:0] standoff;
      logic [31:0] scfg;
      logic [31:0] spos;
      logic [31:0] sspd;
      logic [31:0] half;
      logic [31:0] dest;
      logic        aw_got;
      logic        w_got;
      logic [7:0]  awaddr;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        rvalid;
      logic [1:0]  rresp;
      logic [31:0] rdata;
      hsic_pins_t  meta;
      hsic_pins_t  sync2;
      logic        sync_filt;
      logic        sync_prev;
      logic [CLUT_W+9:0] glitch_cnt;
      hsic_phase_t phase;
      logic        in_ph2;
      logic [31:0] blind_start;
      logic        blind_on;
      logic        done;
      logic        sync_req;
      hsic_move_t  move;
   } hsic_state_t;

   hsic_state_t st_ff;
   hsic_state_t nxt_st;

   ////////////////////////////////////////////////////////////////////////////
   // Byte-lane merge, used by every writable register.
   function automatic logic [31:0] hsic_merge(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  strb);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++)
      begin
         if (strb[i])
         begin
            r[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return r;
   endfunction : hsic_merge

   // Stop signal of the chosen source; an undefined code never stops.
   function automatic logic hsic_stop(input logic [1:0] src, input hsic_pins_t p,
                                      input logic sync_pulse, input logic left);
      logic r;
      r = 1'b0;
      if (src == HSIC_SRC_LIMIT)
      begin
         r = left ? p.lim_left : p.lim_right;
      end
      else if (src == HSIC_SRC_REV)
      begin
         r = p.rev;
      end
      else if (src == HSIC_SRC_SYNC)
      begin
         r = sync_pulse;
      end
      return r;
   endfunction : hsic_stop

   ////////////////////////////////////////////////////////////////////////////
   // Derived values of the sync conditioner, the bus channels and the sequencer.
   logic [CLUT_W+9:0] clut_cycles;
   logic              sync_edge;
   logic              sync_acc;
   logic              fast;
   logic              wr_fire;
   logic              rd_fire;
   logic [31:0]       blind_dist;

   assign clut_cycles = (CLUT_W+10)'(st_ff.scfg[`HSIC_S_CLUT_LO +: CLUT_W]) *
                        (CLUT_W+10)'(`HSIC_CYC_PER_US);
   assign fast        = st_ff.ctrl[`HSIC_C_FAST];
   assign wr_fire     = st_ff.aw_got && st_ff.w_got && !st_ff.bvalid;
   assign rd_fire     = s_axi_arvalid && !st_ff.rvalid;
   // Distance counts the way the stage moves, so the blind span works in both directions.
   assign blind_dist  = !st_ff.in_ph2       ? 32'h0000_0000 :
                        st_ff.move.dir_left ? (st_ff.blind_start - step_count)
                                            : (step_count - st_ff.blind_start);

   // Edge of the filtered level against its last value, so no loop runs through nxt_st.
   assign sync_edge = st_ff.scfg[`HSIC_S_INV] ? (st_ff.sync_prev && !st_ff.sync_filt)
                                              : (!st_ff.sync_prev && st_ff.sync_filt);
   assign sync_acc  = sync_edge && st_ff.scfg[`HSIC_S_EN];

   ////////////////////////////////////////////////////////////////////////////
   // Next-state logic.
   always_comb
   begin
      nxt_st = st_ff;
      // Pins pass two flip-flops before anything reads them.
      nxt_st.meta  = pins_in;
      nxt_st.sync2 = st_ff.meta;
      nxt_st.sync_prev = st_ff.sync_filt;
      // Glitch filter: a level must hold for the clutter time to be taken.
      if (st_ff.sync2.sync_in == st_ff.sync_filt)
      begin
         nxt_st.glitch_cnt = '0;
      end
      else if (st_ff.glitch_cnt + 1'b1 >= clut_cycles)
      begin
         nxt_st.sync_filt  = st_ff.sync2.sync_in;
         nxt_st.glitch_cnt = '0;
      end
      else
      begin
         nxt_st.glitch_cnt = st_ff.glitch_cnt + 1'b1;
      end

      // Write channel: address and data taken in either order.
      if (s_axi_awvalid && !st_ff.aw_got)
      begin
         nxt_st.aw_got = 1'b1;
         nxt_st.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !st_ff.w_got)
      begin
         nxt_st.w_got = 1'b1;
         nxt_st.wdata = s_axi_wdata;
         nxt_st.wstrb = s_axi_wstrb;
      end
      if (st_ff.bvalid && s_axi_bready)
      begin
         nxt_st.bvalid = 1'b0;
      end
      nxt_st.move.valid = 1'b0;
      if (wr_fire)
      begin
         nxt_st.aw_got = 1'b0;
         nxt_st.w_got  = 1'b0;
         nxt_st.bvalid = 1'b1;
         nxt_st.bresp  = 2'b00;
         if (st_ff.awaddr == `HSIC_CTRL_OFS)
         begin
            nxt_st.ctrl = hsic_merge(st_ff.ctrl, st_ff.wdata, st_ff.wstrb);
         end
         else if (st_ff.awaddr == `HSIC_HSPD1_OFS)
         begin
            nxt_st.spd1 = hsic_merge(st_ff.spd1, st_ff.wdata, st_ff.wstrb);
         end
         else if (st_ff.awaddr == `HSIC_HSPD2_OFS)
         begin
            nxt_st.spd2 = hsic_merge(st_ff.spd2, st_ff.wdata, st_ff.wstrb);
         end
         else if (st_ff.awaddr == `HSIC_STANDOFF_OFS)
         begin
            nxt_st.standoff = hsic_merge(st_ff.standoff, st_ff.wdata, st_ff.wstrb);
         end
         else if (st_ff.awaddr == `HSIC_SCFG_OFS)
         begin
            nxt_st.scfg = hsic_merge(st_ff.scfg, st_ff.wdata, st_ff.wstrb);
         end
         else if (st_ff.awaddr == `HSIC_SPOS_OFS)
         begin
            nxt_st.spos = hsic_merge(st_ff.spos, st_ff.wdata, st_ff.wstrb);
         end
         else if (st_ff.awaddr == `HSIC_SSPD_OFS)
         begin
            nxt_st.sspd = hsic_merge(st_ff.sspd, st_ff.wdata, st_ff.wstrb);
         end
         else if (st_ff.awaddr == `HSIC_HALF_OFS)
         begin
            nxt_st.half = hsic_merge(st_ff.half, st_ff.wdata, st_ff.wstrb);
         end
         else if (st_ff.awaddr == `HSIC_DEST_OFS)
         begin
            nxt_st.dest = hsic_merge(st_ff.dest, st_ff.wdata, st_ff.wstrb);
         end
         else
         begin
            nxt_st.bresp = 2'b10;
         end
      end

      // Read channel: answer one cycle after the address is taken.
      if (st_ff.rvalid && s_axi_rready)
      begin
         nxt_st.rvalid = 1'b0;
      end
      if (rd_fire)
      begin
         nxt_st.rvalid = 1'b1;
         nxt_st.rresp  = 2'b00;
         if (s_axi_araddr == `HSIC_CTRL_OFS)           nxt_st.rdata = st_ff.ctrl;
         else if (s_axi_araddr == `HSIC_HSPD1_OFS)     nxt_st.rdata = st_ff.spd1;
         else if (s_axi_araddr == `HSIC_HSPD2_OFS)     nxt_st.rdata = st_ff.spd2;
         else if (s_axi_araddr == `HSIC_STANDOFF_OFS)  nxt_st.rdata = st_ff.standoff;
         else if (s_axi_araddr == `HSIC_SCFG_OFS)      nxt_st.rdata = st_ff.scfg;
         else if (s_axi_araddr == `HSIC_SPOS_OFS)      nxt_st.rdata = st_ff.spos;
         else if (s_axi_araddr == `HSIC_SSPD_OFS)      nxt_st.rdata = st_ff.sspd;
         else if (s_axi_araddr == `HSIC_HALF_OFS)      nxt_st.rdata = st_ff.half;
         else if (s_axi_araddr == `HSIC_DEST_OFS)      nxt_st.rdata = st_ff.dest;
         else if (s_axi_araddr == `HSIC_STAT_OFS)
         begin
            nxt_st.rdata = {27'h000_0000, st_ff.done, st_ff.in_ph2, 2'b00,
                            st_ff.sync_filt};
         end
         else
         begin
            nxt_st.rdata = 32'h0000_0000;
            nxt_st.rresp = 2'b10;
         end
      end

      // Homing sequencer. Start bit self-clears once taken.
      case (st_ff.phase)
         HSIC_IDLE:
         begin
            if (st_ff.ctrl[`HSIC_C_START] && !wr_fire)
            begin
               nxt_st.ctrl[`HSIC_C_START] = 1'b0;
               nxt_st.done       = 1'b0;
               nxt_st.in_ph2     = 1'b0;
               nxt_st.phase      = HSIC_PH1;
               nxt_st.move.valid    = 1'b1;
               nxt_st.move.search   = 1'b1;
               nxt_st.move.relative = 1'b1;
               nxt_st.move.target   = 32'h0000_0000;
               nxt_st.move.dir_left = st_ff.ctrl[`HSIC_C_DIR1];
               // Fast homing searches its first phase at the second-phase speed.
               nxt_st.move.speed = fast ? st_ff.spd2 : st_ff.spd1;
            end
            else if (sync_acc)
            begin
               nxt_st.phase         = HSIC_WAIT_SYNC;
               nxt_st.move.valid    = 1'b1;
               nxt_st.move.search   = 1'b0;
               nxt_st.move.speed    = st_ff.sspd;
               nxt_st.move.relative = !st_ff.scfg[`HSIC_S_ABS];
               nxt_st.move.dir_left = 1'b0;
               // Absolute goes to the set point; relative offsets the destination.
               nxt_st.move.target   = st_ff.scfg[`HSIC_S_ABS] ? st_ff.spos
                                      : st_ff.dest + st_ff.spos;
               nxt_st.dest          = st_ff.scfg[`HSIC_S_ABS] ? st_ff.spos
                                      : st_ff.dest + st_ff.spos;
            end
         end
         HSIC_PH1:
         begin
            if (hsic_stop(st_ff.ctrl[`HSIC_C_SRC1_LO +: 2], st_ff.sync2, sync_acc,
                          st_ff.ctrl[`HSIC_C_DIR1]))
            begin
               nxt_st.move.valid    = 1'b1;
               nxt_st.move.search   = fast || st_ff.ctrl[`HSIC_C_SEC];
               if (fast || st_ff.ctrl[`HSIC_C_SEC])
               begin
                  nxt_st.phase         = HSIC_PH2;
                  nxt_st.in_ph2        = 1'b1;
                  nxt_st.blind_start   = step_count;
                  nxt_st.move.dir_left = fast ? st_ff.ctrl[`HSIC_C_DIR1]
                                              : st_ff.ctrl[`HSIC_C_DIR2];
                  nxt_st.move.speed    = fast ? st_ff.spd1 : st_ff.spd2;
               end
               else
               begin
                  nxt_st.phase         = HSIC_STANDOFF;
                  nxt_st.move.dir_left = st_ff.standoff[31];
                  nxt_st.move.target   = st_ff.standoff;
                  nxt_st.move.speed    = st_ff.spd1;
               end
            end
         end
         HSIC_PH2:
         begin
            if ((!st_ff.ctrl[`HSIC_C_BLIND] || blind_dist >= st_ff.half) &&
                hsic_stop(st_ff.ctrl[`HSIC_C_SRC2_LO +: 2], st_ff.sync2, sync_acc,
                          st_ff.move.dir_left))
            begin
               nxt_st.phase         = HSIC_STANDOFF;
               nxt_st.in_ph2        = 1'b0;
               nxt_st.move.valid    = 1'b1;
               nxt_st.move.search   = 1'b0;
               nxt_st.move.dir_left = st_ff.standoff[31];
               nxt_st.move.target   = st_ff.standoff;
            end
         end
         HSIC_STANDOFF:
         begin
            if (move_done && !st_ff.move.valid)
            begin
               nxt_st.phase = HSIC_IDLE;
               nxt_st.done  = 1'b1;
            end
         end
         HSIC_WAIT_SYNC:
         begin
            if (move_done && !st_ff.move.valid)
            begin
               nxt_st.phase = HSIC_IDLE;
            end
         end
         default:
         begin
            nxt_st.phase = HSIC_IDLE;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register; clock enable freezes everything.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         st_ff          <= '0;
         st_ff.ctrl     <= `HSIC_CTRL_RST;
         st_ff.scfg     <= `HSIC_SCFG_RST;
         st_ff.half     <= `HSIC_HALF_RST;
         st_ff.phase    <= HSIC_IDLE;
      end
      else if (ce)
      begin
         st_ff <= nxt_st;
      end
   end

   // Outputs.
   assign s_axi_awready = !st_ff.aw_got;
   assign s_axi_wready  = !st_ff.w_got;
   assign s_axi_bvalid  = st_ff.bvalid;
   assign s_axi_bresp   = st_ff.bresp;
   assign s_axi_arready = !st_ff.rvalid;
   assign s_axi_rvalid  = st_ff.rvalid;
   assign s_axi_rdata   = st_ff.rdata;
   assign s_axi_rresp   = st_ff.rresp;
   assign move_out      = st_ff.move;
   assign homing_busy   = (st_ff.phase != HSIC_IDLE) && (st_ff.phase != HSIC_WAIT_SYNC);
   assign homing_done   = st_ff.done;

   ////////////////////////////////////////////////////////////////////////////
   // Assertions.
   sequence s_ph1_stop;
      st_ff.phase == HSIC_PH1 && ce && nxt_st.phase != HSIC_PH1;
   endsequence
   property p_ph1_dir;
      @(posedge aclk) disable iff (!aresetn)
      (st_ff.phase == HSIC_IDLE && nxt_st.phase == HSIC_PH1 && ce)
         |=> move_out.valid && move_out.dir_left == $past(st_ff.ctrl[`HSIC_C_DIR1]);
   endproperty
   a_ph1_dir: assert property (p_ph1_dir) else $error("first phase direction wrong");
   property p_ph1_spd;
      @(posedge aclk) disable iff (!aresetn)
      (st_ff.phase == HSIC_IDLE && nxt_st.phase == HSIC_PH1 && ce && !fast)
         |=> move_out.speed == $past(st_ff.spd1);
   endproperty
   a_ph1_spd: assert property (p_ph1_spd) else $error("first phase speed wrong");
   property p_sec_skip;
      @(posedge aclk) disable iff (!aresetn)
      (s_ph1_stop ##0 (!fast && !st_ff.ctrl[`HSIC_C_SEC]))
         |=> st_ff.phase == HSIC_STANDOFF;
   endproperty
   a_sec_skip: assert property (p_sec_skip) else $error("second phase not skipped");
   property p_ph2_spd;
      @(posedge aclk) disable iff (!aresetn)
      (s_ph1_stop ##0 (!fast && st_ff.ctrl[`HSIC_C_SEC]))
         |=> st_ff.phase == HSIC_PH2 && move_out.speed == $past(st_ff.spd2);
   endproperty
   a_ph2_spd: assert property (p_ph2_spd) else $error("second phase speed wrong");
   property p_blind;
      @(posedge aclk) disable iff (!aresetn)
      (st_ff.phase == HSIC_PH2 && st_ff.ctrl[`HSIC_C_BLIND] && blind_dist < st_ff.half && ce)
         |=> st_ff.phase == HSIC_PH2;
   endproperty
   a_blind: assert property (p_blind) else $error("blind half turn violated");
   property p_standoff;
      @(posedge aclk) disable iff (!aresetn)
      (st_ff.phase != HSIC_STANDOFF ##1 st_ff.phase == HSIC_STANDOFF)
         |-> move_out.target == st_ff.standoff && move_out.dir_left == st_ff.standoff[31];
   endproperty
   a_standoff: assert property (p_standoff) else $error("standoff move wrong");
   property p_sync_en;
      @(posedge aclk) disable iff (!aresetn)
      (st_ff.phase == HSIC_IDLE && !st_ff.scfg[`HSIC_S_EN] && !st_ff.ctrl[`HSIC_C_START])
         |=> st_ff.phase != HSIC_WAIT_SYNC;
   endproperty
   a_sync_en: assert property (p_sync_en) else $error("sync acted while disabled");
   property p_sync_spd;
      @(posedge aclk) disable iff (!aresetn)
      (st_ff.phase == HSIC_IDLE ##1 st_ff.phase == HSIC_WAIT_SYNC)
         |-> move_out.valid && move_out.speed == $past(st_ff.sspd);
   endproperty
   a_sync_spd: assert property (p_sync_spd) else $error("sync move speed wrong");
   property p_done;
      @(posedge aclk) disable iff (!aresetn)
      $rose(st_ff.done) |-> $past(st_ff.phase) == HSIC_STANDOFF;
   endproperty
   a_done: assert property (p_done) else $error("done without standoff");

endmodule : hsic_top
